// ===== rtl/crf_core.sv
`timescale 1ns/100ps
module crf_core import crf_pkg::*; #(
  parameter int REGS = RF_COUNT
) (
  input  wire logic            i_clk,
  input  wire logic            i_reset,
  input  wire logic [15:0]     i_prog_word,
  input  wire logic            i_prog_valid,
  input  wire logic            i_fetch_hold,
  input  wire logic            i_fetch_flush,
  output logic [15:0]          o_exec_word,
  output logic                 o_exec_valid,
  input  wire crf_alu_req_type i_alu_req,
  output logic [7:0]           o_rd_data,
  output logic [7:0]           o_rr_data,
  output logic [7:0]           o_alu_result,
  input  wire logic            i_wide_rd_wr,
  input  wire logic            i_wide_wr,
  input  wire logic [3:0]      i_wide_pair,
  input  wire logic [15:0]     i_wide_wdata,
  output logic [15:0]          o_wide_rdata,
  input  wire logic [15:0]     i_ds_addr,
  input  wire logic            i_ds_rd,
  input  wire logic            i_ds_wr,
  input  wire logic [7:0]      i_ds_wdata,
  output logic [7:0]           o_ds_rdata,
  input  wire logic [5:0]      i_io_addr,
  input  wire logic            i_io_rd,
  input  wire logic            i_io_wr,
  input  wire logic [7:0]      i_io_wdata,
  output logic [7:0]           o_io_rdata,
  output logic [15:0]          o_ptr_x,
  output logic [15:0]          o_ptr_y,
  output logic [15:0]          o_ptr_z,
  output logic [15:0]          o_flash_addr,
  input  wire logic            i_irq_pending,
  input  wire logic            i_irq_ready,
  output logic                 o_irq_take,
  input  wire logic            i_irq_return,
  input  wire logic            i_irq_on,
  input  wire logic            i_irq_off,
  output crf_flags_type        o_flags
);
  logic [7:0]    rf_r [REGS];
  logic [7:0]    rf_nxt [REGS];
  crf_flags_type flags_r;
  crf_flags_type flags_nxt;
  logic [15:0]   exec_word_r;
  logic [15:0]   exec_word_nxt;
  logic          exec_valid_r;
  logic          exec_valid_nxt;
  logic [7:0]    result_r;
  logic [7:0]    ds_rdata_r;
  logic [7:0]    ds_rdata_nxt;
  logic [7:0]    io_rdata_r;
  logic [7:0]    io_rdata_nxt;

  // Instruction prefetch stage
  assign exec_word_nxt  = (i_prog_valid & ~i_fetch_hold) ?
                          i_prog_word : exec_word_r;
  assign exec_valid_nxt = i_fetch_flush ? 1'b0 :
                          i_fetch_hold  ? exec_valid_r :
                          i_prog_valid;

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      exec_word_r  <= WORD_RESET;
      exec_valid_r <= 1'b0;
    end else begin
      exec_word_r  <= exec_word_nxt;
      exec_valid_r <= exec_valid_nxt;
    end
  end

  assign o_exec_word  = exec_word_r;
  assign o_exec_valid = exec_valid_r;

  // Operand fetch
  wire [7:0] rd_val = rf_r[i_alu_req.rd];
  wire [7:0] rr_val = rf_r[i_alu_req.rr];
  wire [7:0] b_val  = i_alu_req.use_imm ? i_alu_req.imm : rr_val;

  assign o_rd_data = rd_val;
  assign o_rr_data = rr_val;

  wire [7:0]     alu_res;
  crf_flags_type alu_flags;
  wire [7:0]     alu_mask;
  wire           alu_write;

  crf_alu crf_alu_inst (
    .i_op      (i_alu_req.op),
    .i_a       (rd_val),
    .i_b       (b_val),
    .i_flags   (flags_r),
    .i_bit_sel (i_alu_req.bit_sel),
    .o_res     (alu_res),
    .o_flags   (alu_flags),
    .o_mask    (alu_mask),
    .o_write   (alu_write)
  );

  wire alu_we     = i_alu_req.valid & alu_write;
  wire alu_fl_upd = i_alu_req.valid;

  // Wide pair access for 16-bit result and operand
  wire [4:0]  wide_lo = {i_wide_pair, 1'b0};
  wire [4:0]  wide_hi = {i_wide_pair, 1'b1};
  assign o_wide_rdata = {rf_r[wide_hi], rf_r[wide_lo]};

  // Data-space and I/O-space decode
  wire ds_hit_rf    = (i_ds_addr < DS_RF_LIMIT);
  wire ds_hit_flags = (i_ds_addr == FLAGS_DS_ADDR);
  wire io_hit_flags = (i_io_addr == FLAGS_IO_ADDR);
  wire [4:0] ds_idx = i_ds_addr[4:0];
  wire ds_rf_wr     = i_ds_wr & ds_hit_rf;
  wire sw_ds_fl_wr  = i_ds_wr & ds_hit_flags;
  wire sw_io_fl_wr  = i_io_wr & io_hit_flags;
  wire sw_fl_wr     = sw_ds_fl_wr | sw_io_fl_wr;
  wire [7:0] sw_fl_data = sw_io_fl_wr ? i_io_wdata : i_ds_wdata;

  assign ds_rdata_nxt = ~i_ds_rd     ? ds_rdata_r :
                        ds_hit_rf    ? rf_r[ds_idx] :
                        ds_hit_flags ? flags_r : 8'h00;
  assign io_rdata_nxt = ~i_io_rd     ? io_rdata_r :
                        io_hit_flags ? flags_r : 8'h00;

  // Register file, one flop group per register
  genvar g;
  generate
    for (g = 0; g < REGS; g++) begin : g_rf
      localparam logic [4:0] IDX = 5'(g);
      wire hit_wide = i_wide_wr & (IDX[4:1] == i_wide_pair);
      wire hit_alu  = alu_we & (IDX == i_alu_req.rd);
      wire hit_ds   = ds_rf_wr & (IDX == ds_idx);
      wire [7:0] wide_byte = IDX[0] ? i_wide_wdata[15:8] :
                                      i_wide_wdata[7:0];
      assign rf_nxt[g] = hit_wide ? wide_byte :
                         hit_alu  ? alu_res :
                         hit_ds   ? i_ds_wdata : rf_r[g];

      always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
          rf_r[g] <= 8'h00;
        end else begin
          rf_r[g] <= rf_nxt[g];
        end
      end
    end
  endgenerate

  // Pointer views over the top six registers
  assign o_ptr_x      = {rf_r[PTR_X_LO + 1], rf_r[PTR_X_LO]};
  assign o_ptr_y      = {rf_r[PTR_Y_LO + 1], rf_r[PTR_Y_LO]};
  assign o_ptr_z      = {rf_r[PTR_Z_LO + 1], rf_r[PTR_Z_LO]};
  assign o_flash_addr = o_ptr_z;

  // Interrupt gating
  assign o_irq_take = i_irq_pending & i_irq_ready & flags_r.i;

  // Flag register next value
  wire [7:0] fl_alu = alu_fl_upd ?
                      ((alu_flags & alu_mask) | (flags_r & ~alu_mask)) :
                      flags_r;
  wire fl_i_set = i_irq_return | i_irq_on;
  wire fl_i_clr = o_irq_take | i_irq_off;
  wire fl_i_hw  = fl_i_set ? 1'b1 :
                  fl_i_clr ? 1'b0 : fl_alu[BIT_I];
  wire [7:0] fl_hw = {fl_i_hw, fl_alu[BIT_T:0]};

  assign flags_nxt = sw_fl_wr ? crf_flags_type'(sw_fl_data) :
                     crf_flags_type'(fl_hw);

  // Flags are untouched by interrupt entry apart from the enable
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      flags_r <= crf_flags_type'(FLAGS_RESET);
    end else begin
      flags_r <= flags_nxt;
    end
  end

  // Registered results and read data
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      result_r   <= 8'h00;
      ds_rdata_r <= 8'h00;
      io_rdata_r <= 8'h00;
    end else begin
      result_r   <= alu_we ? alu_res : result_r;
      ds_rdata_r <= ds_rdata_nxt;
      io_rdata_r <= io_rdata_nxt;
    end
  end

  assign o_alu_result = result_r;
  assign o_ds_rdata   = ds_rdata_r;
  assign o_io_rdata   = io_rdata_r;
  assign o_flags      = flags_r;

  // Wide read-modify-write marker is informational for the pair path
  wire unused_wide_rd_wr = i_wide_rd_wr;
endmodule

// ===== rtl/crf_pkg.sv
package crf_pkg;
  localparam int          RF_COUNT      = 32;
  localparam int          DATA_W        = 8;
  localparam logic [15:0] DS_RF_LIMIT   = 16'h0020;
  localparam logic [15:0] IO_OFFSET     = 16'h0020;
  localparam logic [15:0] FLAGS_DS_ADDR = 16'h005F;
  localparam logic [5:0]  FLAGS_IO_ADDR = 6'(FLAGS_DS_ADDR - IO_OFFSET);
  localparam logic [7:0]  FLAGS_RESET   = 8'h00;
  localparam logic [15:0] WORD_RESET    = 16'h0000;
  localparam int          PTR_X_LO      = 26;
  localparam int          PTR_Y_LO      = 28;
  localparam int          PTR_Z_LO      = 30;
  localparam int          BIT_I         = 7;
  localparam int          BIT_T         = 6;
  localparam int          BIT_H         = 5;
  localparam int          BIT_S         = 4;
  localparam int          BIT_V         = 3;
  localparam int          BIT_N         = 2;
  localparam int          BIT_Z         = 1;
  localparam int          BIT_C         = 0;
  localparam logic [7:0]  MASK_ARITH    = 8'h3F;
  localparam logic [7:0]  MASK_LOGIC    = 8'h1E;
  localparam logic [7:0]  MASK_SHIFT    = 8'h1F;
  localparam logic [7:0]  MASK_INCDEC   = 8'h1E;
  localparam logic [7:0]  MASK_T        = 8'h40;
  localparam logic [7:0]  MASK_NONE     = 8'h00;

  typedef enum logic [4:0] {
    OP_NONE  = 5'h00,
    OP_ADD   = 5'h01,
    OP_ADC   = 5'h02,
    OP_SUB   = 5'h03,
    OP_SBC   = 5'h04,
    OP_AND   = 5'h05,
    OP_OR    = 5'h06,
    OP_EOR   = 5'h07,
    OP_COM   = 5'h08,
    OP_NEG   = 5'h09,
    OP_INC   = 5'h0A,
    OP_DEC   = 5'h0B,
    OP_LSR   = 5'h0C,
    OP_ROR   = 5'h0D,
    OP_ASR   = 5'h0E,
    OP_SWAP  = 5'h0F,
    OP_MOV   = 5'h10,
    OP_CP    = 5'h11,
    OP_BIT_STORE = 5'h12,
    OP_BIT_LOAD  = 5'h13
  } crf_alu_op_type;

  typedef struct packed {
    logic i;
    logic t;
    logic h;
    logic s;
    logic v;
    logic n;
    logic z;
    logic c;
  } crf_flags_type;

  typedef struct packed {
    logic           valid;
    crf_alu_op_type op;
    logic [4:0]     rd;
    logic [4:0]     rr;
    logic [7:0]     imm;
    logic           use_imm;
    logic [2:0]     bit_sel;
  } crf_alu_req_type;
endpackage

// ===== rtl/crf_alu.sv
`timescale 1ns/100ps
module crf_alu import crf_pkg::*; (
  input  wire crf_alu_op_type i_op,
  input  wire logic [7:0]     i_a,
  input  wire logic [7:0]     i_b,
  input  wire crf_flags_type  i_flags,
  input  wire logic [2:0]     i_bit_sel,
  output logic [7:0]          o_res,
  output crf_flags_type       o_flags,
  output logic [7:0]          o_mask,
  output logic                o_write
);
  wire       cin_add = (i_op == OP_ADC) & i_flags.c;
  wire       cin_sub = (i_op == OP_SBC) & i_flags.c;
  wire [8:0] add_w   = {1'b0, i_a} + {1'b0, i_b} + {8'h00, cin_add};
  wire [8:0] sub_w   = {1'b0, i_a} - {1'b0, i_b} - {8'h00, cin_sub};
  wire [7:0] neg_w   = 8'h00 - i_a;
  wire [7:0] bit_one = 8'h01 << i_bit_sel;

  logic [7:0] r;
  logic       h;
  logic       v;
  logic       c;
  logic       zero_chain;

  always_comb begin
    r          = i_a;
    h          = i_flags.h;
    v          = i_flags.v;
    c          = i_flags.c;
    zero_chain = 1'b0;
    o_mask     = MASK_NONE;
    o_write    = 1'b1;
    case (i_op)
      OP_ADD, OP_ADC: begin
        r = add_w[7:0];
        c = add_w[8];
        h = (i_a[3] & i_b[3]) | (i_b[3] & ~r[3]) | (~r[3] & i_a[3]);
        v = (i_a[7] & i_b[7] & ~r[7]) | (~i_a[7] & ~i_b[7] & r[7]);
        o_mask = MASK_ARITH;
      end
      OP_SUB, OP_SBC, OP_CP: begin
        r = sub_w[7:0];
        c = sub_w[8];
        h = (~i_a[3] & i_b[3]) | (i_b[3] & r[3]) | (r[3] & ~i_a[3]);
        v = (i_a[7] & ~i_b[7] & ~r[7]) | (~i_a[7] & i_b[7] & r[7]);
        zero_chain = (i_op == OP_SBC);
        o_mask  = MASK_ARITH;
        o_write = (i_op != OP_CP);
      end
      OP_AND, OP_OR, OP_EOR: begin
        r = (i_op == OP_AND) ? (i_a & i_b) :
            (i_op == OP_OR)  ? (i_a | i_b) : (i_a ^ i_b);
        v = 1'b0;
        o_mask = MASK_LOGIC;
      end
      OP_COM: begin
        r = ~i_a;
        v = 1'b0;
        c = 1'b1;
        o_mask = MASK_SHIFT;
      end
      OP_NEG: begin
        r = neg_w;
        c = (neg_w != 8'h00);
        h = neg_w[3] | i_a[3];
        v = (neg_w == 8'h80);
        o_mask = MASK_ARITH;
      end
      OP_INC, OP_DEC: begin
        r = (i_op == OP_INC) ? (i_a + 8'h01) : (i_a - 8'h01);
        v = (i_op == OP_INC) ? (r == 8'h80) : (r == 8'h7F);
        o_mask = MASK_INCDEC;
      end
      OP_LSR, OP_ROR, OP_ASR: begin
        r = (i_op == OP_LSR) ? {1'b0, i_a[7:1]} :
            (i_op == OP_ROR) ? {i_flags.c, i_a[7:1]} : {i_a[7], i_a[7:1]};
        c = i_a[0];
        v = r[7] ^ i_a[0];
        o_mask = MASK_SHIFT;
      end
      OP_SWAP: r = {i_a[3:0], i_a[7:4]};
      OP_MOV:  r = i_b;
      OP_BIT_STORE: begin
        o_write = 1'b0;
        o_mask  = MASK_T;
      end
      OP_BIT_LOAD: r = i_flags.t ? (i_a | bit_one) : (i_a & ~bit_one);
      default: o_write = 1'b0;
    endcase
  end

  always_comb begin
    o_res     = r;
    o_flags   = i_flags;
    o_flags.t = |(i_a & bit_one);
    o_flags.h = h;
    o_flags.v = v;
    o_flags.n = r[7];
    o_flags.z = zero_chain ? ((r == 8'h00) & i_flags.z) : (r == 8'h00);
    o_flags.s = r[7] ^ v;
    o_flags.c = c;
  end
endmodule

// ===== testbench/crf_fetch_model.sv
`timescale 1ns/100ps
module crf_fetch_model (
  input  wire logic   i_clk,
  input  wire logic   i_reset,
  input  wire logic   i_irq_take,
  output logic [15:0] o_prog_word,
  output logic        o_prog_valid,
  output logic        o_irq_ready
);
  logic [3:0] cnt_r;
  // Word offered each cycle, one gap in sixteen
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      cnt_r        <= 4'h0;
      o_prog_word  <= 16'h0000;
      o_prog_valid <= 1'h0;
      o_irq_ready  <= 1'h0;
    end else begin
      cnt_r        <= cnt_r + 4'h1;
      o_prog_word  <= o_prog_word + 16'h0001;
      o_prog_valid <= cnt_r != 4'hF;
      // Entry saves no flags; handler code keeps them
      o_irq_ready  <= !i_irq_take;
    end
  end
endmodule

// ===== testbench/crf_core_chk.sv
`timescale 1ns/100ps
module crf_core_chk import crf_pkg::*; #(
  parameter int REGS = RF_COUNT
) (
  input wire logic            i_clk,
  input wire logic            i_reset,
  input wire logic [15:0]     i_prog_word,
  input wire logic            i_prog_valid,
  input wire logic            i_fetch_hold,
  input wire logic            i_fetch_flush,
  input wire logic [15:0]     o_exec_word,
  input wire logic            o_exec_valid,
  input wire crf_alu_req_type i_alu_req,
  input wire logic [15:0]     i_ds_addr,
  input wire logic            i_ds_rd,
  input wire logic            i_ds_wr,
  input wire logic [7:0]      o_ds_rdata,
  input wire logic            i_io_wr,
  input wire logic [5:0]      i_io_addr,
  input wire logic [7:0]      i_io_wdata,
  input wire logic [15:0]     o_ptr_z,
  input wire logic [15:0]     o_flash_addr,
  input wire logic            i_irq_pending,
  input wire logic            i_irq_ready,
  input wire logic            o_irq_take,
  input wire logic            i_irq_return,
  input wire logic            i_irq_on,
  input wire crf_flags_type   o_flags
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  wire sw_w  = i_ds_wr | i_io_wr;
  wire arith = i_alu_req.op == OP_ADD || i_alu_req.op == OP_SUB;
  sequence quiet_s;
    !sw_w && !i_alu_req.valid;
  endsequence
  sequence flag_rd_s;
    i_ds_rd && i_ds_addr == FLAGS_DS_ADDR ##0 quiet_s;
  endsequence
  fetch_load_a: assert property (
    i_prog_valid && !i_fetch_hold && !i_fetch_flush
    |=> o_exec_word == $past(i_prog_word)) else $error("exec word stale");
  flush_drop_a: assert property (
    i_fetch_flush |=> !o_exec_valid) else $error("exec valid kept on flush");
  irq_gate_a: assert property (
    o_irq_take == (i_irq_pending && i_irq_ready && o_flags.i))
    else $error("irq take gating wrong");
  irq_clear_a: assert property (
    o_irq_take && !i_irq_return && !i_irq_on && !sw_w |=> !o_flags.i)
    else $error("enable kept after take");
  irq_set_a: assert property (
    (i_irq_on || i_irq_return) && !sw_w |=> o_flags.i)
    else $error("enable not set");
  sign_flag_a: assert property (
    i_alu_req.valid && arith && !sw_w |=> o_flags.s == (o_flags.n ^ o_flags.v))
    else $error("sign flag wrong");
  flash_ptr_a: assert property (
    o_flash_addr == o_ptr_z) else $error("flash address wrong");
  flag_read_a: assert property (
    flag_rd_s |=> o_ds_rdata == $past(o_flags)) else $error("flag read wrong");
  sw_wins_a: assert property (
    i_io_wr && i_io_addr == FLAGS_IO_ADDR |=> o_flags == $past(i_io_wdata))
    else $error("flag write lost");
endmodule

// ===== testbench/tb_crf_core.sv
`timescale 1ns/100ps
module tb_crf_core;
  import crf_pkg::*;
  logic            i_clk, i_reset, i_prog_valid, i_fetch_hold, i_fetch_flush;
  logic [15:0]     i_prog_word, o_exec_word, i_wide_wdata, o_wide_rdata;
  logic [15:0]     i_ds_addr, o_ptr_x, o_ptr_y, o_ptr_z, o_flash_addr;
  logic            o_exec_valid, i_wide_rd_wr, i_wide_wr, i_irq_off;
  logic            i_ds_rd, i_ds_wr, i_io_rd, i_io_wr, i_irq_on;
  logic            i_irq_pending, i_irq_ready, o_irq_take, i_irq_return;
  logic [7:0]      o_rd_data, o_rr_data, o_alu_result, i_ds_wdata;
  logic [7:0]      o_ds_rdata, i_io_wdata, o_io_rdata, a, b, r, fl;
  logic [3:0]      i_wide_pair;
  logic [5:0]      i_io_addr;
  crf_alu_req_type i_alu_req;
  crf_flags_type   o_flags;
  crf_alu_op_type  op;
  int              n_fail, comparisons, seed;
  logic [7:0]      rf [32];
  logic [7:0]      q_ds [$];
  logic [7:0]      q_io [$];
  crf_core crf_core_inst (.*);
  crf_fetch_model crf_fetch_model_inst (.i_clk(i_clk), .i_reset(i_reset),
    .i_irq_take(o_irq_take), .o_prog_word(i_prog_word),
    .o_prog_valid(i_prog_valid), .o_irq_ready(i_irq_ready));
  task automatic report_and_stop;
    if (n_fail == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(logic [15:0] got, logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic tick;
    @(posedge i_clk);
    #1;
  endtask
  // Every access and interrupt strobe set once per cycle; the ALU request valid stays set until idle clears it
  task automatic drive(logic [4:0] s, logic [2:0] q);
    {i_ds_wr, i_ds_rd, i_io_wr, i_io_rd, i_wide_wr} = s;
    {i_irq_on, i_irq_off, i_irq_return} = q;
    tick;
  endtask
  task automatic ds(logic w, logic [15:0] ad, logic [7:0] d);
    i_ds_addr = ad;
    i_ds_wdata = d;
    if (!w) q_ds.push_back(d);
    drive({w, !w, 3'h0}, 3'h0);
  endtask
  task automatic io(logic w, logic [5:0] ad, logic [7:0] d);
    i_io_addr = ad;
    i_io_wdata = d;
    if (!w) q_io.push_back(d);
    drive({2'h0, w, !w, 1'h0}, 3'h0);
  endtask
  task automatic alu(crf_alu_op_type o, logic [4:0] rd, logic [7:0] im,
                     logic ui, logic [2:0] bs);
    i_alu_req = '{1'h1, o, rd, 5'h02, im, ui, bs};
    drive(5'h00, 3'h0);
  endtask
  task automatic idle;
    i_alu_req.valid = 1'h0;
    drive(5'h00, 3'h0);
  endtask
  function automatic logic [7:0] af(logic s, logic [7:0] x, y, q, f);
    logic [7:0] u, w;
    u = s ? ~x : x;
    w = s ? ~q : q;
    return {f[7:6], u[3] & y[3] | y[3] & ~w[3] | ~w[3] & u[3],
            q[7] ^ (u[7] & y[7] & ~w[7] | ~u[7] & ~y[7] & w[7]),
            u[7] & y[7] & ~w[7] | ~u[7] & ~y[7] & w[7], q[7], q == 8'h00,
            u[7] & y[7] | y[7] & ~w[7] | ~w[7] & u[7]};
  endfunction
  initial begin
    i_clk = 1'h0;
    forever #50 i_clk = ~i_clk;
  end
  initial begin : mon
    logic d, o;
    forever begin
      @(posedge i_clk);
      d = i_ds_rd;
      o = i_io_rd;
      #2;
      if (d) chk(o_ds_rdata, q_ds.pop_front());
      if (o) chk(o_io_rdata, q_io.pop_front());
    end
  end
  initial begin
    repeat (20000) @(posedge i_clk);
    n_fail++;
    report_and_stop;
  end
  initial begin
    {i_fetch_hold, i_fetch_flush} = 2'h0;
    forever begin
      @(posedge i_clk);
      #1;
      i_fetch_hold = 1'($random(seed));
      i_fetch_flush = 3'($random(seed)) == 3'h0;
    end
  end
  initial begin
    {n_fail, comparisons, seed, i_reset, fl} = {96'd80, 1'h1, 8'h00};
    {i_ds_addr, i_ds_wdata, i_io_addr, i_io_wdata, i_wide_pair} = 42'h0;
    {i_wide_wdata, i_wide_rd_wr, i_irq_pending} = 18'h0;
    i_alu_req = '0;
    drive(5'h00, 3'h0);
    repeat (7) tick;
    i_reset = 1'h0;
    tick;
    ds(1'h0, FLAGS_DS_ADDR, 8'h00);
    io(1'h0, FLAGS_IO_ADDR, 8'h00);
    for (int k = 0; k < 32; k++) begin
      rf[k] = 8'($random(seed));
      ds(1'h1, 16'(k), rf[k]);
    end
    for (int k = 0; k < 32; k++) ds(1'h0, 16'(k), rf[k]);
    ds(1'h1, 16'h0040, 8'hA5);
    ds(1'h0, 16'h0040, 8'h00);
    i_wide_pair = 4'hF;
    i_wide_wdata = 16'($random(seed));
    drive(5'h01, 3'h0);
    {i_alu_req.rd, i_alu_req.rr, i_wide_pair} = {5'h1A, 5'h1B, 4'hD};
    drive(5'h00, 3'h0);
    chk(o_ptr_x, {rf[27], rf[26]});
    chk(o_ptr_y, {rf[29], rf[28]});
    chk(o_ptr_z, i_wide_wdata);
    chk(o_wide_rdata, {rf[27], rf[26]});
    chk({o_rr_data, o_rd_data}, {rf[27], rf[26]});
    for (int k = 0; k < 12; k++) begin
      {a, b} = 16'($random(seed));
      ds(1'h1, 16'h0001, a);
      ds(1'h1, 16'h0002, b);
      op = k % 3 == 0 ? OP_ADD : k % 3 == 1 ? OP_SUB : OP_AND;
      r = op == OP_ADD ? a + b : op == OP_SUB ? a - b : a & b;
      fl = op == OP_AND ? {fl[7:5], r[7], 1'h0, r[7], r == 8'h00, fl[0]}
                        : af(op == OP_SUB, a, b, r, fl);
      alu(op, 5'h01, b, op == OP_SUB, 3'h0);
      idle;
      chk(o_alu_result, r);
      io(1'h0, FLAGS_IO_ADDR, fl);
      ds(1'h0, 16'h0001, r);
    end
    fl[6] = r[3];
    b[5] = r[3];
    alu(OP_BIT_STORE, 5'h01, 8'h00, 1'h0, 3'h3);
    alu(OP_BIT_LOAD, 5'h02, 8'h00, 1'h0, 3'h5);
    idle;
    io(1'h0, FLAGS_IO_ADDR, fl);
    ds(1'h0, 16'h0002, b);
    drive(5'h00, 3'h4);
    i_irq_pending = 1'h1;
    idle;
    repeat (2) tick;
    i_irq_pending = 1'h0;
    io(1'h0, FLAGS_IO_ADDR, fl);
    drive(5'h00, 3'h1);
    io(1'h0, FLAGS_IO_ADDR, fl | 8'h80);
    drive(5'h00, 3'h2);
    io(1'h0, FLAGS_IO_ADDR, fl);
    fl = 8'($random(seed));
    i_alu_req = '{1'h1, OP_ADD, 5'h03, 5'h02, 8'h00, 1'h0, 3'h0};
    i_io_addr = FLAGS_IO_ADDR;
    i_io_wdata = fl;
    drive(5'h04, 3'h4);
    idle;
    ds(1'h0, FLAGS_DS_ADDR, fl);
    chk(o_alu_result, {8'h00, 8'(rf[3] + b)});
    idle;
    report_and_stop;
  end
endmodule
bind crf_core crf_core_chk #(.REGS(REGS)) crf_core_chk_inst (.*);
